/* File: design/auil_lamps_power.sv */
// Function
// - event start lights stretched lamp 6 ms
// - duration lamp follows event length exactly
// - serial output to data pair is send event
// - control-in collision is collision event unless heartbeat-masked
// - heartbeat burst keeps collision lamps dark
// - carrier on incoming data or collision
// - heartbeat alone never starts or extends carrier
// - supply lamp shows transceiver 12 V feed
// - software switches transceiver 12 V feed
// - over-current trips feed off until re-enabled
// - one retry, repeated trip flagged for report
// - readable power on/off status bit
// - diag lamp lit: others show test codes
// - send lamp while processing and transmitting
// - receive lamp for own-address frame
// - monitor lamp while monitoring foreign traffic
// - download sets, execute clears firmware lamp
// - boot lamp while ROM firmware runs
// - idle-wait lamp while polling for work
// - check lamp during background hardware test
// - send event spans encoder enable
// - collision ends 200 ns after last transition
// - carrier ends 200 ns after data, or later
// - collision within 5.3 us after send masked
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
module auil_lamps_power
  import auil_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = auil_pkg::STRETCH_CYC
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // aui side pins
  input wire logic encoder_en_pin,
  input wire logic control_in_pin,
  input wire logic data_in_pin,
  // transceiver power
  input wire logic mau_overcurrent_pin,
  output logic mau_power_en,
  output logic mau_supply_lamp,
  // aui lamp pairs, bit 1 duration, bit 0 start-stretched
  output logic [1:0] send_pair_lamps,
  output logic [1:0] collision_lamps,
  output logic [1:0] carrier_lamps,
  // processor activity lamps, bit order as in the lamp register
  output logic [7:0] cpu_lamps
);
  import auil_pkg::*;

  localparam logic [SHORT_W-1:0] TAIL_LOAD = SHORT_W'(TAIL_CYC);
  localparam logic [SHORT_W-1:0] HB_LOAD = SHORT_W'(HB_MASK_CYC);
  localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(STRETCH_CYCLES);

  // byte-address decode shared by the read and write paths
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == REG_MAU_CTRL) || (a == REG_MAU_STAT) || (a == REG_CPU_LAMPS) ||
                 (a == REG_DIAG_CODE) || (a == REG_FW_CMD) || (a == REG_AUI_STAT);
  endfunction

  // pin synchronisers: three stages, filtered value moves when stages 2 and 3 agree
  logic [3:0] pin_raw;
  logic [3:0] sync1_q, sync2_q, sync3_q, pin_q;
  assign pin_raw = {mau_overcurrent_pin, data_in_pin, control_in_pin, encoder_en_pin};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
    end else if (clk_en) begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // filtered pin levels and the previous filtered level for edge detection
  logic [3:0] pin_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_q[i] <= sync3_q[i];
        end
      end
      pin_prev_q <= pin_q;
    end
  end

  logic send_ev, ci_edge, di_edge, send_fall, trip_edge;
  assign send_ev = pin_q[0];
  assign ci_edge = pin_q[1] ^ pin_prev_q[1];
  assign di_edge = pin_q[2] ^ pin_prev_q[2];
  assign send_fall = pin_prev_q[0] & ~pin_q[0];
  assign trip_edge = pin_q[3] & ~pin_prev_q[3];

  // collision hold-off: each control-in transition reloads the tail
  logic [SHORT_W-1:0] col_tail_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col_tail_q <= '0;
    end else if (clk_en) begin
      if (ci_edge) begin
        col_tail_q <= TAIL_LOAD;
      end else if (col_tail_q != '0) begin
        col_tail_q <= col_tail_q - SHORT_W'(1);
      end
    end
  end

  // incoming data hold-off, same shape as the collision tail
  logic [SHORT_W-1:0] di_tail_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      di_tail_q <= '0;
    end else if (clk_en) begin
      if (di_edge) begin
        di_tail_q <= TAIL_LOAD;
      end else if (di_tail_q != '0) begin
        di_tail_q <= di_tail_q - SHORT_W'(1);
      end
    end
  end

  // heartbeat window after our own transmit ends; a collision that starts
  // inside it is tagged for its whole length so late edges cannot light lamps
  logic [SHORT_W-1:0] hb_win_q;
  logic hb_tag_q;
  logic col_active, col_start;
  assign col_active = ci_edge | (col_tail_q != '0);
  assign col_start = ci_edge & (col_tail_q == '0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hb_win_q <= '0;
    end else if (clk_en) begin
      if (send_ev) begin
        hb_win_q <= '0;
      end else if (send_fall) begin
        hb_win_q <= HB_LOAD;
      end else if (hb_win_q != '0) begin
        hb_win_q <= hb_win_q - SHORT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hb_tag_q <= 1'b0;
    end else if (clk_en) begin
      if (col_start) begin
        hb_tag_q <= (hb_win_q != '0) | send_fall;
      end else if (!col_active) begin
        hb_tag_q <= 1'b0;
      end
    end
  end

  // the three monitored events as levels
  logic [EV_N-1:0] ev_level;
  logic hb_now;
  assign hb_now = col_start ? ((hb_win_q != '0) | send_fall) : hb_tag_q;
  assign ev_level[EV_SEND] = send_ev;
  assign ev_level[EV_COL] = col_active & ~hb_now;
  assign ev_level[EV_CAR] = (di_edge | (di_tail_q != '0)) | ev_level[EV_COL];

  // per-event lamp pair: stretched start lamp and duration lamp
  logic [EV_N-1:0] ev_prev_q;
  logic [EV_N-1:0] dur_lamp_q;
  logic [EV_N-1:0] start_lamp_q;
  genvar g;
  generate
    for (g = 0; g < EV_N; g++) begin : g_event
      logic [STRETCH_W-1:0] stretch_q;
      // a rising level restarts the stretch so closely spaced events merge
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stretch_q <= '0;
          start_lamp_q[g] <= 1'b0;
        end else if (clk_en) begin
          if (ev_level[g] && !ev_prev_q[g]) begin
            stretch_q <= STRETCH_LOAD - STRETCH_W'(1);
            start_lamp_q[g] <= 1'b1;
          end else if (stretch_q != '0) begin
            stretch_q <= stretch_q - STRETCH_W'(1);
          end else begin
            start_lamp_q[g] <= 1'b0;
          end
        end
      end
      // duration lamp mirrors the event level
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ev_prev_q[g] <= 1'b0;
          dur_lamp_q[g] <= 1'b0;
        end else if (clk_en) begin
          ev_prev_q[g] <= ev_level[g];
          dur_lamp_q[g] <= ev_level[g];
        end
      end
    end
  endgenerate

  assign send_pair_lamps = {dur_lamp_q[EV_SEND], start_lamp_q[EV_SEND]};
  assign collision_lamps = {dur_lamp_q[EV_COL], start_lamp_q[EV_COL]};
  assign carrier_lamps = {dur_lamp_q[EV_CAR], start_lamp_q[EV_CAR]};

  // axi write channel capture: address and data may come in either order
  logic aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
      // ready drops for the beat after a handshake, back once the slot empties
      s_axi_awready <= ~aw_full_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_full_q & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl, wr_stat, wr_lamps, wr_diag, wr_fw;
  assign wr_ctrl = wr_fire & (aw_addr_q == REG_MAU_CTRL) & w_strb_q[0];
  assign wr_stat = wr_fire & (aw_addr_q == REG_MAU_STAT) & w_strb_q[0];
  assign wr_lamps = wr_fire & (aw_addr_q == REG_CPU_LAMPS) & w_strb_q[0];
  assign wr_diag = wr_fire & (aw_addr_q == REG_DIAG_CODE) & w_strb_q[0];
  assign wr_fw = wr_fire & (aw_addr_q == REG_FW_CMD) & w_strb_q[0];

  // transceiver feed: software switches it, an over-current edge drops it
  // and it stays off until software turns it on again
  logic mau_on_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mau_on_q <= 1'b0;
    end else if (clk_en) begin
      if (trip_edge) begin
        mau_on_q <= 1'b0;
      end else if (wr_ctrl) begin
        mau_on_q <= w_data_q[MAU_ON_BIT];
      end
    end
  end

  // trip flags: sticky, cleared by writing one; a trip in the clearing cycle wins.
  // a second trip before the first is cleared marks the failed retry to report
  logic trip_q, repeat_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_q <= 1'b0;
      repeat_q <= 1'b0;
    end else if (clk_en) begin
      if (trip_edge) begin
        trip_q <= 1'b1;
      end else if (wr_stat && w_data_q[TRIP_BIT]) begin
        trip_q <= 1'b0;
      end
      if (trip_edge && trip_q) begin
        repeat_q <= 1'b1;
      end else if (wr_stat && w_data_q[REPEAT_BIT]) begin
        repeat_q <= 1'b0;
      end
    end
  end

  // power outputs straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mau_power_en <= 1'b0;
      mau_supply_lamp <= 1'b0;
    end else if (clk_en) begin
      mau_power_en <= mau_on_q & ~trip_edge;
      mau_supply_lamp <= mau_on_q & ~trip_edge;
    end
  end

  // processor activity lamps and self-test codes
  logic [7:0] lamps_q;
  logic [6:0] diag_code_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamps_q <= CPU_LAMPS_RST;
      diag_code_q <= DIAG_CODE_RST;
    end else if (clk_en) begin
      if (wr_lamps) begin
        lamps_q <= w_data_q[7:0];
      end else if (wr_fw && w_data_q[FW_EXEC_BIT]) begin
        lamps_q[3] <= 1'b0;
        lamps_q[4] <= 1'b0;
      end else if (wr_fw && w_data_q[FW_LOAD_BIT]) begin
        lamps_q[3] <= 1'b1;
      end
      if (wr_diag) begin
        diag_code_q <= w_data_q[6:0];
      end
    end
  end

  // diag lamp lit: the seven others carry the test code instead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_lamps <= CPU_LAMPS_RST;
    end else if (clk_en) begin
      cpu_lamps <= lamps_q[LAMP_DIAG_BIT] ? {1'b1, diag_code_q} : lamps_q;
    end
  end

  // read path: one read at a time, data one cycle after the address handshake
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      REG_MAU_CTRL: rd_word[MAU_ON_BIT] = mau_on_q;
      REG_MAU_STAT: rd_word[2:0] = {repeat_q, trip_q, mau_on_q};
      REG_CPU_LAMPS: rd_word[7:0] = lamps_q;
      REG_DIAG_CODE: rd_word[6:0] = diag_code_q;
      REG_AUI_STAT: rd_word[8:0] = {ev_level, dur_lamp_q, start_lamp_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // auil_lamps_power

/* File: include/auil_pkg.sv */
package auil_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ = 100;
  // event timing, figures in their own units
  localparam int unsigned STRETCH_US = 6000;
  localparam int unsigned TAIL_NS = 200;
  localparam int unsigned HEARTBEAT_MASK_NS = 5300;
  // derived cycle counts (least times, rounded up)
  localparam int unsigned STRETCH_CYC = STRETCH_US * CLK_MHZ;
  localparam int unsigned TAIL_CYC = (TAIL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HB_MASK_CYC = (HEARTBEAT_MASK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STRETCH_W = 20;
  localparam int unsigned SHORT_W = 10;
  // register byte offsets
  localparam logic [7:0] REG_MAU_CTRL = 8'h00;
  localparam logic [7:0] REG_MAU_STAT = 8'h04;
  localparam logic [7:0] REG_CPU_LAMPS = 8'h08;
  localparam logic [7:0] REG_DIAG_CODE = 8'h0c;
  localparam logic [7:0] REG_FW_CMD = 8'h10;
  localparam logic [7:0] REG_AUI_STAT = 8'h14;
  // field positions
  localparam int unsigned MAU_ON_BIT = 0;
  localparam int unsigned TRIP_BIT = 1;
  localparam int unsigned REPEAT_BIT = 2;
  localparam int unsigned FW_LOAD_BIT = 0;
  localparam int unsigned FW_EXEC_BIT = 1;
  localparam int unsigned LAMP_DIAG_BIT = 7;
  // cpu lamp order: send, receive, monitor, fw load, boot, idle, check, diag
  localparam logic [7:0] CPU_LAMPS_RST = 8'hff;
  localparam logic [6:0] DIAG_CODE_RST = 7'h7f;
  // event indices
  localparam int unsigned EV_SEND = 0;
  localparam int unsigned EV_COL = 1;
  localparam int unsigned EV_CAR = 2;
  localparam int unsigned EV_N = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: tb/auil_chk.sv */
module auil_chk
  import auil_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = 50
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus and pins
  input wire logic s_axi_bvalid,
  input wire logic encoder_en_pin,
  input wire logic control_in_pin,
  input wire logic data_in_pin,
  input wire logic mau_overcurrent_pin,
  // outputs watched
  input wire logic mau_power_en,
  input wire logic mau_supply_lamp,
  input wire logic [1:0] send_pair_lamps,
  input wire logic [1:0] collision_lamps,
  input wire logic [1:0] carrier_lamps,
  input wire logic [7:0] cpu_lamps
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ci_p, di_p, dur_p;
  int unsigned ci_q, di_q, st_q, hb_q;

  // quiet time per pair, stretch length, heartbeat window (kept shorter than the design's)
  always_ff @(posedge aclk) begin
    ci_p <= control_in_pin;
    di_p <= data_in_pin;
    dur_p <= send_pair_lamps[1];
    if (!aresetn) begin
      ci_q <= 0;
      di_q <= 0;
      st_q <= 0;
      hb_q <= 0;
    end else begin
      ci_q <= (control_in_pin != ci_p) ? 0 : ci_q + 1;
      di_q <= (data_in_pin != di_p) ? 0 : di_q + 1;
      st_q <= (!dur_p && send_pair_lamps[1]) ? 1 : (send_pair_lamps[0] ? st_q + 1 : 0);
      hb_q <= (dur_p && !send_pair_lamps[1]) ? 500 : ((hb_q != 0) ? hb_q - 1 : 0);
    end
  end

  AST_RST_STATE: assert property (disable iff (1'b0) !aresetn |=>
    cpu_lamps == CPU_LAMPS_RST && !mau_power_en && send_pair_lamps == 2'h0 &&
    collision_lamps == 2'h0 && carrier_lamps == 2'h0) else $error("reset state wrong");
  AST_SUPPLY_LAMP: assert property (mau_supply_lamp == mau_power_en)
    else $error("supply lamp differs from feed");
  AST_TRIP_OFF: assert property ($rose(mau_overcurrent_pin) ##1 mau_overcurrent_pin[*7]
    |=> !mau_power_en) else $error("feed not cut on over-current");
  // the feed flop lands one cycle after the response rises, so look one cycle back
  AST_ON_BY_WRITE: assert property ($rose(mau_power_en) |-> $past(s_axi_bvalid))
    else $error("feed came on without a write");
  AST_SEND_ON: assert property (encoder_en_pin[*8] |-> send_pair_lamps[1])
    else $error("send duration lamp dark");
  AST_SEND_OFF: assert property (!encoder_en_pin[*8] |-> !send_pair_lamps[1])
    else $error("send duration lamp stuck");
  AST_STRETCH: assert property ($fell(send_pair_lamps[0]) |->
    st_q + 2 >= STRETCH_CYCLES && st_q <= STRETCH_CYCLES + 2) else $error("stretch length");
  AST_HB_MASK: assert property (hb_q != 0 && collision_lamps == 2'h0
    |=> collision_lamps == 2'h0) else $error("collision lit after send");
  AST_COL_CAR: assert property (collision_lamps[1] |-> carrier_lamps[1])
    else $error("carrier dark during collision");
  AST_COL_HOLD: assert property (collision_lamps[1] && ci_q < 16 |=> collision_lamps[1])
    else $error("collision ended early");
  AST_CAR_END: assert property (ci_q > 30 && di_q > 30 |-> !carrier_lamps[1])
    else $error("carrier stuck");
endmodule // auil_chk

bind auil_lamps_power auil_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) i_auil_chk (.aclk, .aresetn,
  .s_axi_bvalid, .encoder_en_pin, .control_in_pin, .data_in_pin, .mau_overcurrent_pin,
  .mau_power_en, .mau_supply_lamp, .send_pair_lamps, .collision_lamps, .carrier_lamps,
  .cpu_lamps);

/* File: tb/auil_lamps_power_tb_top.sv */
module auil_lamps_power_tb_top;
  import auil_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STR = 40;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cpu_lamps;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, send_pair_lamps, collision_lamps, carrier_lamps;
  logic encoder_en_pin, control_in_pin, data_in_pin, mau_overcurrent_pin;
  logic mau_power_en, mau_supply_lamp, clk_en;
  logic [3:0] s_axi_wstrb;
  logic [5:0] lp;
  int n_fail = 0;
  int n_compared = 0;
  int n;

  assign lp = {carrier_lamps, collision_lamps, send_pair_lamps};
  // short stretch keeps the run brief
  auil_lamps_power #(.STRETCH_CYCLES(STR)) i_auil_lamps_power (.aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .encoder_en_pin, .control_in_pin, .data_in_pin, .mau_overcurrent_pin, .mau_power_en,
    .mau_supply_lamp, .send_pair_lamps, .collision_lamps, .carrier_lamps, .cpu_lamps);
  auil_mau_model i_auil_mau_model (.aclk, .encoder_en_pin, .control_in_pin, .data_in_pin,
    .mau_overcurrent_pin);

  always #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // write: address and data offered together, bready held until the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        b = 1'b1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic r;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        r = 1'b1;
        rs = s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // cycles a lamp stays lit from its next rise
  task automatic lamp_len(input int b, output int c);
    c = 0;
    while (lp[b] !== 1'b1) @(posedge aclk);
    while (lp[b] === 1'b1) begin
      c++;
      @(posedge aclk);
    end
  endtask

  task automatic t_reset();
    chk(32'(cpu_lamps), 32'h0000_00ff, "cpu lamps");
    chk(32'({mau_power_en, lp}), 32'h0, "aui lamps");
    axi_rd(REG_DIAG_CODE);
    chk(rd, 32'h0000_007f, "diag code");
    $display("reset test done");
  endtask

  task automatic t_power();
    axi_wr(REG_MAU_CTRL, 32'h0000_0001);
    @(posedge aclk);
    chk(32'({mau_power_en, mau_supply_lamp}), 32'h3, "feed on");
    // a write with byte 0 not enabled must leave the feed alone
    s_axi_wstrb <= 4'h0;
    axi_wr(REG_MAU_CTRL, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    axi_rd(REG_MAU_STAT);
    chk(rd, 32'h1, "feed status");
    axi_rd(8'h18);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    axi_wr(8'h18, 32'hffff_ffff);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    $display("power test done");
  endtask

  task automatic t_trip();
    i_auil_mau_model.overcurrent(10);
    repeat (4) @(posedge aclk);
    chk(32'({mau_power_en, mau_supply_lamp}), 32'h0, "trip");
    axi_rd(REG_MAU_STAT);
    chk(rd, 32'h2, "trip flag");
    axi_wr(REG_MAU_CTRL, 32'h0000_0001);
    i_auil_mau_model.overcurrent(10);
    repeat (4) @(posedge aclk);
    axi_rd(REG_MAU_STAT);
    chk(rd, 32'h6, "repeat trip");
    axi_wr(REG_MAU_STAT, 32'h0000_0006);
    axi_rd(REG_MAU_STAT);
    chk(rd, 32'h0, "flags cleared");
    $display("trip test done");
  endtask

  task automatic t_lamps();
    for (int i = 0; i < 7; i++) begin
      axi_wr(REG_CPU_LAMPS, 32'(1 << i));
      repeat (2) @(posedge aclk);
      chk(32'(cpu_lamps), 32'(1 << i), "cpu lamp");
    end
    axi_wr(REG_DIAG_CODE, 32'h0000_0015);
    axi_wr(REG_CPU_LAMPS, 32'h0000_0080);
    repeat (2) @(posedge aclk);
    chk(32'(cpu_lamps), 32'h0000_0095, "diag codes");
    axi_wr(REG_CPU_LAMPS, 32'h0000_0010);
    axi_wr(REG_FW_CMD, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(32'(cpu_lamps), 32'h0000_0018, "download");
    axi_wr(REG_FW_CMD, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk(32'(cpu_lamps), 32'h0, "execute");
    $display("cpu lamp test done");
  endtask

  task automatic t_send();
    fork
      begin
        i_auil_mau_model.transmit(20);
        chk(32'(lp[1:0]), 32'h3, "send lit");
        repeat (8) @(posedge aclk);
        chk(32'(lp[1:0]), 32'h1, "send ended");
      end
      lamp_len(0, n);
    join
    chk(n, STR, "stretch");
    fork
      begin
        i_auil_mau_model.transmit(10);
        repeat (20) @(posedge aclk);
        i_auil_mau_model.transmit(10);
      end
      lamp_len(0, n);
    join
    chk(n, STR + 31, "restart");
    $display("send test done");
  endtask

  task automatic t_heartbeat();
    n = 0;
    fork
      begin
        i_auil_mau_model.transmit(20);
        repeat (10) @(posedge aclk);
        i_auil_mau_model.burst(1'b1, 3);
        repeat (250) @(posedge aclk);
        i_auil_mau_model.burst(1'b1, 4);
      end
      repeat (400) begin
        @(posedge aclk);
        if (lp[5:2] !== 4'h0) n++;
      end
    join
    chk(n, 0, "heartbeat lit");
    repeat (600) @(posedge aclk);
    $display("heartbeat test done");
  endtask

  task automatic t_col_car();
    fork
      i_auil_mau_model.burst(1'b1, 10);
      lamp_len(2, n);
      begin
        repeat (30) @(posedge aclk);
        chk(32'(lp[5:2]), 32'hf, "collision");
      end
    join
    chk(n, STR, "col stretch");
    repeat (40) @(posedge aclk);
    chk(32'(lp[5:2]), 32'h0, "col end");
    fork
      i_auil_mau_model.burst(1'b0, 10);
      begin
        repeat (30) @(posedge aclk);
        chk(32'(lp[5:2]), 32'hc, "carrier");
      end
    join
    repeat (40) @(posedge aclk);
    chk(32'(lp[5:4]), 32'h0, "car end");
    $display("collision test done");
  endtask

  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog, about ten times the expected run
  initial begin
    #200us;
    n_fail++;
    $display("Error at %0t: timeout", $time);
    end_sim();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_power();
    t_trip();
    t_lamps();
    t_send();
    t_heartbeat();
    t_col_car();
    end_sim();
  end
endmodule // auil_lamps_power_tb_top

/* File: tb/auil_mau_model.sv */
module auil_mau_model (
  // clock
  input wire logic aclk,
  // pins toward the block
  output logic encoder_en_pin,
  output logic control_in_pin,
  output logic data_in_pin,
  output logic mau_overcurrent_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pairs hold still: only transitions carry meaning
  initial begin
    encoder_en_pin = 1'b0;
    control_in_pin = 1'b0;
    data_in_pin = 1'b0;
    mau_overcurrent_pin = 1'b0;
  end

  // one frame: encoder enabled for n cycles
  task automatic transmit(input int n);
    @(posedge aclk);
    encoder_en_pin <= 1'b1;
    repeat (n) @(posedge aclk);
    encoder_en_pin <= 1'b0;
  endtask

  // 10 MHz signal, a transition every 5 cycles
  task automatic burst(input bit ci, input int n);
    repeat (n) begin
      repeat (5) @(posedge aclk);
      if (ci) control_in_pin <= ~control_in_pin;
      else data_in_pin <= ~data_in_pin;
    end
  endtask

  // supply current above limit for n cycles
  task automatic overcurrent(input int n);
    @(posedge aclk);
    mau_overcurrent_pin <= 1'b1;
    repeat (n) @(posedge aclk);
    mau_overcurrent_pin <= 1'b0;
  endtask
endmodule // auil_mau_model
